// File: hdl/pcitio_target.sv
/*
 target i/o command handler: decides retry, wait or disconnect-with-data for
 i/o read and write, holds one delayed read and one delayed write, feeds the
 application through a read fifo and a write fifo; also encodes master i/o commands.
 assumes the bus side presents one decoded address phase at a time and takes answers.
*/
`timescale 1ns/1ps
`include "pcitio_defines.svh"
module pcitio_target #(
   parameter int FIFO_DEPTH = `PCITIO_FIFO_DEPTH
) (
   input  wire logic        core_clk_in,        // clock
   input  wire logic        rst_in,             // sync reset
   input  wire logic        dt_sel_in,          // 0 delayed, 1 nondelayed while rd_burst_pend_n_in is low
   input  wire logic        rd_burst_pend_n_in, // read burst pending, active low
   input  wire logic        lat32_sel_in,       // 1: 32-clock latency
   input  wire logic        req_valid_in,       // address phase
   output logic             req_ready_out,      // phase taken
   input  wire logic [3:0]  req_cmd_in,         // bus command
   input  wire logic [31:0] req_addr_in,        // address
   input  wire logic [3:0]  req_be_n_in,        // byte enables
   input  wire logic [31:0] req_wdata_in,       // write data
   input  wire logic        req_burst_in,       // master wants more phases
   output logic             resp_valid_out,     // answer pulse
   output logic             resp_retry_out,     // retry
   output logic             resp_disc_out,      // disconnect with data
   output logic             resp_wait_out,      // inserting wait states
   output logic [31:0]      resp_rdata_out,     // read data
   output logic             app_rd_req_out,     // read request pulse
   output logic [31:0]      app_rd_addr_out,    // stored read address
   output logic [3:0]       app_rd_be_n_out,    // stored read byte enables
   input  wire logic        app_rd_valid_in,    // read data push
   output logic             app_rd_ready_out,   // read fifo not full
   input  wire logic [31:0] app_rd_data_in,     // read data
   output logic             app_wr_valid_out,   // write word ready
   input  wire logic        app_wr_ready_in,    // application takes word
   output logic [31:0]      app_wr_addr_out,    // write address
   output logic [3:0]       app_wr_be_n_out,    // write byte enables
   output logic [31:0]      app_wr_data_out,    // write data
   input  wire logic        mst_req_in,         // master i/o request
   input  wire logic        mst_write_in,       // 1 write, 0 read
   input  wire logic        mst_burst_in,       // burst request
   output logic [3:0]       mst_cmd_out,        // command to drive
   output logic             mst_burst_out       // burst to drive
);
   pcitio_pkg::pcitio_state_type state_reg, state_next;
   logic        rd_held_reg, rd_held_next;
   logic [31:0] rd_addr_reg, rd_addr_next;
   logic [3:0]  rd_be_reg, rd_be_next;
   logic        wr_held_reg, wr_held_next;
   logic [31:0] wr_addr_reg, wr_addr_next;
   logic [3:0]  wr_be_reg, wr_be_next;
   logic [31:0] wr_data_reg, wr_data_next;
   logic        rv_reg, rv_next;
   logic        retry_reg, retry_next;
   logic        disc_reg, disc_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        appreq_reg, appreq_next;
   logic        rf_pop, wf_push, tmr_start;
   logic        rf_valid, wf_ready, wf_valid, lat_expired;
   logic [31:0] rf_data;
   logic [67:0] wf_data;

   // decode of the address phase
   wire take     = req_valid_in && req_ready_out;
   wire is_rd    = req_cmd_in == `PCITIO_CMD_IO_RD;
   wire is_wr    = req_cmd_in == `PCITIO_CMD_IO_WR;
   // special, reserved and anything else stay unclaimed
   wire is_io    = is_rd || is_wr;
   // burst pending high in nondelayed select is taken as delayed: the safe reading
   wire delayed  = !dt_sel_in || rd_burst_pend_n_in;
   wire wr_block = wr_held_reg && wf_valid;
   wire rd_match = rd_held_reg && req_addr_in == rd_addr_reg && req_be_n_in == rd_be_reg;
   wire wr_match = wr_held_reg && req_addr_in == wr_addr_reg && req_be_n_in == wr_be_reg
                   && req_wdata_in == wr_data_reg;
   wire waiting  = state_reg == pcitio_pkg::PCITIO_WAIT;

   assign req_ready_out   = state_reg == pcitio_pkg::PCITIO_IDLE;
   assign resp_valid_out  = rv_reg;
   assign resp_retry_out  = retry_reg;
   assign resp_disc_out   = disc_reg;
   assign resp_rdata_out  = rdata_reg;
   assign resp_wait_out   = waiting;
   assign app_rd_req_out  = appreq_reg;
   assign app_rd_addr_out = rd_addr_reg;
   assign app_rd_be_n_out = rd_be_reg;
   assign app_wr_addr_out = wf_data[67:36];
   assign app_wr_be_n_out = wf_data[35:32];
   assign app_wr_data_out = wf_data[31:0];

   always_comb begin
      state_next   = state_reg;
      rd_held_next = rd_held_reg;
      rd_addr_next = rd_addr_reg;
      rd_be_next   = rd_be_reg;
      wr_held_next = wr_held_reg;
      wr_addr_next = wr_addr_reg;
      wr_be_next   = wr_be_reg;
      wr_data_next = wr_data_reg;
      rv_next      = 1'b0;
      retry_next   = 1'b0;
      disc_next    = 1'b0;
      rdata_next   = rdata_reg;
      appreq_next  = 1'b0;
      rf_pop       = 1'b0;
      wf_push      = 1'b0;
      tmr_start    = 1'b0;
      case (state_reg)
         pcitio_pkg::PCITIO_IDLE: begin
            // every answer is retry or one phase then disconnect
            if (take && is_io) begin
               rv_next = 1'b1;
               if (wr_block) begin
                  retry_next = 1'b1;
               end else if (is_rd && rd_held_reg) begin
                  if (rf_valid && rd_match) begin
                     disc_next    = 1'b1;
                     rdata_next   = rf_data;
                     rf_pop       = 1'b1;
                     rd_held_next = 1'b0;
                  end else begin
                     retry_next = 1'b1;
                  end
               end else if (is_rd) begin
                  rd_addr_next = req_addr_in;
                  rd_be_next   = req_be_n_in;
                  appreq_next  = 1'b1;
                  if (delayed) begin
                     retry_next   = 1'b1;
                     rd_held_next = 1'b1;
                  end else begin
                     rv_next    = 1'b0;
                     tmr_start  = 1'b1;
                     state_next = pcitio_pkg::PCITIO_WAIT;
                  end
               end else if (wr_held_reg) begin
                  if (wr_match) begin
                     disc_next    = 1'b1;
                     wr_held_next = 1'b0;
                  end else begin
                     retry_next = 1'b1;
                  end
               end else if (!wf_ready) begin
                  retry_next = 1'b1;
               end else begin
                  wf_push = 1'b1;
                  if (delayed) begin
                     retry_next   = 1'b1;
                     wr_held_next = 1'b1;
                     wr_addr_next = req_addr_in;
                     wr_be_next   = req_be_n_in;
                     wr_data_next = req_wdata_in;
                  end else begin
                     disc_next = 1'b1;
                  end
               end
            end
         end
         pcitio_pkg::PCITIO_WAIT: begin
            if (rf_valid) begin
               rv_next    = 1'b1;
               disc_next  = 1'b1;
               rdata_next = rf_data;
               rf_pop     = 1'b1;
               state_next = pcitio_pkg::PCITIO_IDLE;
            end else if (lat_expired) begin
               // address stays in rd_addr_reg, late data stays in the fifo
               rv_next      = 1'b1;
               retry_next   = 1'b1;
               rd_held_next = 1'b1;
               state_next   = pcitio_pkg::PCITIO_IDLE;
            end
         end
         default: state_next = pcitio_pkg::PCITIO_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         state_reg   <= pcitio_pkg::PCITIO_IDLE;
         rd_held_reg <= 1'b0;
         wr_held_reg <= 1'b0;
         rv_reg      <= 1'b0;
         retry_reg   <= 1'b0;
         disc_reg    <= 1'b0;
         appreq_reg  <= 1'b0;
      end else begin
         state_reg   <= state_next;
         rd_held_reg <= rd_held_next;
         wr_held_reg <= wr_held_next;
         rv_reg      <= rv_next;
         retry_reg   <= retry_next;
         disc_reg    <= disc_next;
         appreq_reg  <= appreq_next;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         rd_addr_reg <= '0;
         rd_be_reg   <= '0;
         wr_addr_reg <= '0;
         wr_be_reg   <= '0;
         wr_data_reg <= '0;
         rdata_reg   <= '0;
      end else begin
         rd_addr_reg <= rd_addr_next;
         rd_be_reg   <= rd_be_next;
         wr_addr_reg <= wr_addr_next;
         wr_be_reg   <= wr_be_next;
         wr_data_reg <= wr_data_next;
         rdata_reg   <= rdata_next;
      end
   end

   // master command encoder, registered
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         mst_cmd_out   <= '0;
         mst_burst_out <= 1'b0;
      end else if (mst_req_in) begin
         mst_cmd_out   <= mst_write_in ? `PCITIO_CMD_IO_WR : `PCITIO_CMD_IO_RD;
         mst_burst_out <= mst_burst_in;
      end
   end

   pcitio_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
      .core_clk_in  (core_clk_in),
      .rst_in       (rst_in),
      .in_valid_in  (app_rd_valid_in),
      .in_ready_out (app_rd_ready_out),
      .in_data_in   (app_rd_data_in),
      .out_valid_out(rf_valid),
      .out_ready_in (rf_pop),
      .out_data_out (rf_data)
   );

   // posted writes carry address and byte enables so back-to-back posts stay apart
   pcitio_fifo #(.WIDTH(68), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
      .core_clk_in  (core_clk_in),
      .rst_in       (rst_in),
      .in_valid_in  (wf_push),
      .in_ready_out (wf_ready),
      .in_data_in   ({req_addr_in, req_be_n_in, req_wdata_in}),
      .out_valid_out(wf_valid),
      .out_ready_in (app_wr_ready_in),
      .out_data_out (wf_data)
   );
   assign app_wr_valid_out = wf_valid;

   pcitio_lat_timer u_lat (
      .core_clk_in(core_clk_in),
      .rst_in     (rst_in),
      .start_in   (tmr_start),
      .run_in     (waiting),
      .lat32_in   (lat32_sel_in),
      .expired_out(lat_expired)
   );

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   a_special_ignored: assert property (take && req_cmd_in == `PCITIO_CMD_SPECIAL |=> !resp_valid_out)
      else $error("special cycle was answered");
   a_reserved_ignored: assert property (take && req_cmd_in == `PCITIO_CMD_RSVD |=> !resp_valid_out)
      else $error("reserved command was answered");
   a_single_answer: assert property (resp_valid_out |-> (resp_retry_out ^ resp_disc_out))
      else $error("answer is not exactly retry or disconnect");
   a_delayed_read_retry: assert property (take && is_rd && delayed && !rd_held_reg && !wr_block
      |=> resp_retry_out && rd_held_reg && app_rd_req_out && app_rd_addr_out == $past(req_addr_in))
      else $error("first delayed read not retried and stored");
   a_nd_read_waits: assert property (take && is_rd && !dt_sel_in == 1'b0 && !rd_burst_pend_n_in
      && !rd_held_reg && !wr_block |=> resp_wait_out && !resp_valid_out)
      else $error("nondelayed read did not wait");
   a_wait_bound: assert property ($rose(resp_wait_out) |-> ##[1:32] !resp_wait_out)
      else $error("wait states exceed latency count");
   a_wait_short: assert property (resp_wait_out && !rf_valid && !lat_expired
      |=> resp_wait_out && !resp_valid_out)
      else $error("wait ended early with no data");
   a_held_retry: assert property (take && is_rd && rd_held_reg && !rf_valid && !wr_block
      |=> resp_retry_out)
      else $error("held read without data not retried");
   a_read_clear: assert property (rf_pop && !waiting |=> resp_disc_out && !rd_held_reg)
      else $error("matched read did not complete and clear");
   a_nd_deliver: assert property (waiting && rf_valid |=> resp_disc_out && !resp_wait_out)
      else $error("data in time not delivered");
   a_timeout_hold: assert property (waiting && lat_expired && !rf_valid
      |=> resp_retry_out && rd_held_reg && $stable(rd_addr_reg))
      else $error("timeout did not hold read");
   a_write_stored: assert property (take && is_wr && delayed && !wr_held_reg && wf_ready
      |=> resp_retry_out && wr_held_reg && wr_data_reg == $past(req_wdata_in))
      else $error("delayed write not stored");
   a_write_block: assert property (take && is_io && wr_block |=> resp_retry_out)
      else $error("access not retried while write pending");
   a_write_match: assert property (take && is_wr && wr_match && !wr_block |=> resp_disc_out && !wr_held_reg)
      else $error("matching write not completed");
   a_write_post: assert property (take && is_wr && !delayed && !wr_held_reg && wf_ready
      |=> resp_disc_out ##0 app_wr_valid_out)
      else $error("nondelayed write not posted");
   a_master_cmd: assert property (mst_req_in |=> mst_cmd_out == ($past(mst_write_in) ? `PCITIO_CMD_IO_WR
      : `PCITIO_CMD_IO_RD) && mst_burst_out == $past(mst_burst_in))
      else $error("master command wrong");

   c_delayed_read: cover property (take && is_rd ##1 resp_retry_out ##[1:40] resp_disc_out);
   c_nd_in_time: cover property (waiting && rf_valid);
   c_nd_timeout: cover property (waiting && lat_expired);
   c_delayed_write: cover property (wr_held_reg ##1 !wr_held_reg);
   c_burst_cut: cover property (take && is_io && req_burst_in ##1 resp_disc_out);
endmodule : pcitio_target

// File: hdl/pcitio_defines.svh
/*
 constants of the target i/o command handler: command codes, latency counts, buffer depth.
 assumes inclusion by bare name from every design file that needs them.
*/
`ifndef PCITIO_DEFINES_SVH
`define PCITIO_DEFINES_SVH
`define PCITIO_CMD_SPECIAL 4'h1
`define PCITIO_CMD_IO_RD   4'h2
`define PCITIO_CMD_IO_WR   4'h3
`define PCITIO_CMD_RSVD    4'h4
`define PCITIO_LAT_SHORT   6'h10
`define PCITIO_LAT_LONG    6'h20
`define PCITIO_FIFO_DEPTH  8
`endif

// File: hdl/pcitio_pkg.sv
/*
 types of the target i/o command handler.
 assumes nothing beyond a sv-2012 compiler.
*/
package pcitio_pkg;
   typedef enum logic [0:0] {PCITIO_IDLE, PCITIO_WAIT} pcitio_state_type;
endpackage : pcitio_pkg

// File: hdl/pcitio_fifo.sv
/*
 synchronous fifo, valid/ready on both sides, register storage.
 assumes one clock and a synchronous active-high reset; depth a power of two.
*/
`timescale 1ns/1ps
module pcitio_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input  wire logic             core_clk_in,  // clock
   input  wire logic             rst_in,       // sync reset
   input  wire logic             in_valid_in,  // push request
   output logic                  in_ready_out, // not full
   input  wire logic [WIDTH-1:0] in_data_in,   // push data
   output logic                  out_valid_out,// not empty
   input  wire logic             out_ready_in, // pop
   output logic      [WIDTH-1:0] out_data_out  // head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0]      wr_ptr_reg;
   logic [AW:0]      rd_ptr_reg;
   wire              push = in_valid_in && in_ready_out;
   wire              pop  = out_valid_out && out_ready_in;
   assign in_ready_out  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
   assign out_valid_out = wr_ptr_reg != rd_ptr_reg;
   assign out_data_out  = mem_reg[rd_ptr_reg[AW-1:0]];
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (push) mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
   end
endmodule : pcitio_fifo

// File: hdl/pcitio_lat_timer.sv
/*
 initial latency timer for nondelayed reads; expires after 16 or 32 clocks.
 assumes start is a one-cycle pulse and run stays high while waiting.
*/
`timescale 1ns/1ps
`include "pcitio_defines.svh"
module pcitio_lat_timer (
   input  wire logic core_clk_in, // clock
   input  wire logic rst_in,      // sync reset
   input  wire logic start_in,    // begin a wait
   input  wire logic run_in,      // waiting
   input  wire logic lat32_in,    // 1: long count
   output logic      expired_out  // last wait state
);
   logic [5:0] count_reg;
   wire  [5:0] limit = lat32_in ? `PCITIO_LAT_LONG : `PCITIO_LAT_SHORT;
   assign expired_out = run_in && (count_reg == limit - 6'h01);
   always_ff @(posedge core_clk_in) begin
      if (rst_in || start_in) count_reg <= '0;
      else if (run_in && !expired_out) count_reg <= count_reg + 6'h01;
   end
endmodule : pcitio_lat_timer

// File: dv/pcitio_app_model.sv
/*
 application-side model: answers read requests after a set delay, drains the write fifo slowly.
 assumes the target's app ports and one clock with a synchronous active-high reset.
*/
`timescale 1ns/1ps
module pcitio_app_model (
   input  wire logic        core_clk_in,      // clock
   input  wire logic        rst_in,           // sync reset
   input  wire logic        app_rd_req_in,    // read request pulse
   input  wire logic [31:0] app_rd_addr_in,   // stored read address
   input  wire logic        app_rd_ready_in,  // read fifo not full
   output logic             app_rd_valid_out, // read data push
   output logic      [31:0] app_rd_data_out,  // read data
   input  wire logic        app_wr_valid_in,  // write word ready
   output logic             app_wr_ready_out, // take write word
   input  wire logic [31:0] app_wr_data_in,   // write data
   input  wire logic [7:0]  rd_delay_in,      // cycles before read data
   input  wire logic        wr_hold_in,       // 1: stall the drain
   output logic      [7:0]  wr_count_out,     // words drained
   output logic      [31:0] wr_last_out       // last drained data
);
   logic [7:0] cnt_reg;
   logic       armed_reg;
   logic       slow_reg;
   // half-rate drain: the target must cope with a sluggish consumer
   assign app_wr_ready_out = ~wr_hold_in & slow_reg;
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         cnt_reg          <= 8'h00;
         armed_reg        <= 1'b0;
         slow_reg         <= 1'b0;
         app_rd_valid_out <= 1'b0;
         app_rd_data_out  <= 32'h0000_0000;
         wr_count_out     <= 8'h00;
         wr_last_out      <= 32'h0000_0000;
      end else begin
         slow_reg <= ~slow_reg;
         if (app_rd_valid_out && app_rd_ready_in) begin
            app_rd_valid_out <= 1'b0;
         end
         if (app_rd_req_in) begin
            armed_reg <= 1'b1;
            cnt_reg   <= rd_delay_in;
         end else if (armed_reg && cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
         end else if (armed_reg) begin
            armed_reg        <= 1'b0;
            app_rd_valid_out <= 1'b1;
            app_rd_data_out  <= app_rd_addr_in ^ 32'h5A5A_5A5A;
         end
         if (app_wr_valid_in && app_wr_ready_out) begin
            wr_count_out <= wr_count_out + 8'h01;
            wr_last_out  <= app_wr_data_in;
         end
      end
   end
endmodule : pcitio_app_model

// File: dv/pcitio_target_tb.sv
/*
 self-checking bench of the target i/o command handler with the application model.
 assumes the design's contract: answers one cycle after take or after a nondelayed read's wait states, inputs driven 1 ns after the edge.
*/
`timescale 1ns/1ps
`include "pcitio_defines.svh"
module pcitio_target_tb;
   logic clk = 1'b0, rst = 1'b1, dt = 1'b0, pend_n = 1'b0, lat32 = 1'b0;
   logic rv = 1'b0, burst = 1'b0, mreq = 1'b0, mwr = 1'b0, mburst = 1'b0, hold = 1'b0;
   logic [3:0] cmd = 4'h0, be = 4'h0;
   logic [31:0] addr = 32'h0000_0000, wd = 32'h0000_0000;
   logic [7:0] dly = 8'h03;
   wire logic rdy, resp_v, retry, disc, waiting, rd_req, rd_rdy, rd_v, wr_v, wr_rdy, mst_b;
   wire logic [31:0] rdata, rd_addr, rd_d, wr_addr, wr_d, wr_last;
   wire logic [3:0] rd_be, wr_be, mst_c;
   wire logic [7:0] wr_cnt;
   logic r_valid, r_retry, r_disc;
   logic [31:0] r_data;
   int n_wait, n_mismatch = 0, comparisons = 0;
   logic [8:0] rows [0:7] = '{9'h020, 9'h030, 9'h080, 9'h090, 9'h010, 9'h0B0, 9'h07D, 9'h075};
   logic [7:0] base;
   initial begin
      forever #5 clk = ~clk;
   end
   pcitio_target DUT (.core_clk_in(clk), .rst_in(rst), .dt_sel_in(dt), .rd_burst_pend_n_in(pend_n),
      .lat32_sel_in(lat32), .req_valid_in(rv), .req_ready_out(rdy), .req_cmd_in(cmd), .req_addr_in(addr),
      .req_be_n_in(be), .req_wdata_in(wd), .req_burst_in(burst), .resp_valid_out(resp_v),
      .resp_retry_out(retry), .resp_disc_out(disc), .resp_wait_out(waiting), .resp_rdata_out(rdata),
      .app_rd_req_out(rd_req), .app_rd_addr_out(rd_addr), .app_rd_be_n_out(rd_be), .app_rd_valid_in(rd_v),
      .app_rd_ready_out(rd_rdy), .app_rd_data_in(rd_d), .app_wr_valid_out(wr_v), .app_wr_ready_in(wr_rdy),
      .app_wr_addr_out(wr_addr), .app_wr_be_n_out(wr_be), .app_wr_data_out(wr_d), .mst_req_in(mreq),
      .mst_write_in(mwr), .mst_burst_in(mburst), .mst_cmd_out(mst_c), .mst_burst_out(mst_b));
   pcitio_app_model app (.core_clk_in(clk), .rst_in(rst), .app_rd_req_in(rd_req), .app_rd_addr_in(rd_addr),
      .app_rd_ready_in(rd_rdy), .app_rd_valid_out(rd_v), .app_rd_data_out(rd_d), .app_wr_valid_in(wr_v),
      .app_wr_ready_out(wr_rdy), .app_wr_data_in(wr_d), .rd_delay_in(dly), .wr_hold_in(hold),
      .wr_count_out(wr_cnt), .wr_last_out(wr_last));
   task automatic chk_bit(input logic got, input logic exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask : chk_bit
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk_word
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cycles
   // one address phase; waits out the answer, a silent target after 40 cycles
   task automatic acc(input logic [3:0] c, input logic [31:0] a, input logic [31:0] d, input logic b);
      cmd = c;
      addr = a;
      be = a[3:0];
      wd = d;
      burst = b;
      rv = 1'b1;
      while (rdy !== 1'b1) cycles(1);
      cycles(1);
      rv = 1'b0;
      n_wait = 0;
      r_valid = 1'b0;
      for (int i = 0; i < 40 && r_valid !== 1'b1; i++) begin
         if (resp_v === 1'b1) begin
            r_valid = 1'b1;
            r_retry = retry;
            r_disc = disc;
            r_data = rdata;
         end else begin
            n_wait += (waiting === 1'b1);
            cycles(1);
         end
      end
      if (r_valid === 1'b1) cycles(1);
   endtask : acc
   task automatic ans(input logic ev, input logic er, input logic ed);
      chk_bit(r_valid, ev, "answer given");
      if (ev) chk_bit(r_retry, er, "retry");
      if (ev) chk_bit(r_disc, ed, "disconnect");
   endtask : ans
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      #100000;
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      cycles(16);
      rst = 1'b0;
      cycles(1);
      chk_bit(rdy, 1'b1, "ready after reset");
      chk_bit(resp_v | wr_v | rd_req, 1'b0, "quiet after reset");
      chk_bit(rd_rdy, 1'b1, "read fifo empty");
      // ordinary cases: ignored codes and posted writes
      foreach (rows[i]) begin
         dt = rows[i][4];
         base = wr_cnt;
         acc(rows[i][8:5], 32'h0000_1000 + i, 32'hC0DE_0000 + i, rows[i][3]);
         ans(rows[i][2], rows[i][1], rows[i][0]);
         cycles(6);
         if (rows[i][2]) chk_word(wr_last, 32'hC0DE_0000 + i, "posted data");
         chk_word(wr_cnt, base + rows[i][2], "drained words");
      end
      // delayed read, select low
      dt = 1'b0;
      dly = 8'h06;
      acc(`PCITIO_CMD_IO_RD, 32'h0000_2004, 0, 1'b1);
      ans(1, 1, 0);
      chk_word(rd_addr, 32'h0000_2004, "held read address");
      chk_bit(rd_be === 4'h4, 1'b1, "held read bytes");
      acc(`PCITIO_CMD_IO_RD, 32'h0000_2004, 0, 1'b0);
      ans(1, 1, 0);
      cycles(12);
      acc(`PCITIO_CMD_IO_RD, 32'h0000_2008, 0, 1'b0);
      ans(1, 1, 0);
      acc(`PCITIO_CMD_IO_RD, 32'h0000_2004, 0, 1'b1);
      ans(1, 0, 1);
      chk_word(r_data, 32'h5A5A_7A5E, "delayed read data");
      acc(`PCITIO_CMD_IO_RD, 32'h0000_2004, 0, 1'b0);
      ans(1, 1, 0);
      cycles(12);
      acc(`PCITIO_CMD_IO_RD, 32'h0000_2004, 0, 1'b0);
      ans(1, 0, 1);
      // delayed write; select high with the burst pending line high (no burst pending) also counts as delayed
      dt = 1'b1;
      pend_n = 1'b1;
      hold = 1'b1;
      base = wr_cnt;
      acc(`PCITIO_CMD_IO_WR, 32'h0000_3001, 32'h1234_5678, 1'b0);
      ans(1, 1, 0);
      chk_bit(wr_v, 1'b1, "held write offered");
      chk_word(wr_addr ^ wr_d, 32'h0000_3001 ^ 32'h1234_5678, "held write word");
      chk_bit(wr_be === 4'h1, 1'b1, "held write bytes");
      acc(`PCITIO_CMD_IO_RD, 32'h0000_3001, 0, 1'b0);
      ans(1, 1, 0);
      acc(`PCITIO_CMD_IO_WR, 32'h0000_3001, 32'h1234_5678, 1'b0);
      ans(1, 1, 0);
      hold = 1'b0;
      cycles(6);
      chk_word(wr_cnt, base + 8'h01, "held write taken");
      acc(`PCITIO_CMD_IO_WR, 32'h0000_3001, 32'h1234_5678, 1'b0);
      ans(1, 0, 1);
      acc(`PCITIO_CMD_IO_WR, 32'h0000_3002, 32'h1234_5678, 1'b0);
      ans(1, 1, 0);
      cycles(6);
      acc(`PCITIO_CMD_IO_WR, 32'h0000_3002, 32'h1234_5678, 1'b0);
      ans(1, 0, 1);
      // nondelayed read, data in time
      pend_n = 1'b0;
      dly = 8'h03;
      acc(`PCITIO_CMD_IO_RD, 32'h0000_4000, 0, 1'b1);
      ans(1, 0, 1);
      chk_word(r_data, 32'h5A5A_1A5A, "prompt read data");
      chk_bit(n_wait >= 1 && n_wait <= 16, 1'b1, "prompt wait states");
      // nondelayed read, latency runs out at 16 then at 32
      dly = 8'h50;
      for (int l = 0; l < 2; l++) begin
         lat32 = l[0];
         acc(`PCITIO_CMD_IO_RD, 32'h0000_5000 + l, 0, 1'b0);
         ans(1, 1, 0);
         chk_bit(n_wait >= 15 + 16 * l && n_wait <= 17 + 16 * l, 1'b1, "latency count");
         chk_word(rd_addr, 32'h0000_5000 + l, "kept read address");
         cycles(90);
         acc(`PCITIO_CMD_IO_RD, 32'h0000_5000 + l, 0, 1'b0);
         ans(1, 0, 1);
         chk_word(r_data, (32'h0000_5000 + l) ^ 32'h5A5A_5A5A, "late read data");
      end
      // write fifo fills while the application stalls
      hold = 1'b1;
      base = wr_cnt;
      for (int i = 0; i < `PCITIO_FIFO_DEPTH; i++) begin
         acc(`PCITIO_CMD_IO_WR, 32'h0000_6000 + i, 32'hF000_0000 + i, 1'b0);
         ans(1, 0, 1);
      end
      acc(`PCITIO_CMD_IO_WR, 32'h0000_6010, 32'hF000_0010, 1'b0);
      ans(1, 1, 0);
      hold = 1'b0;
      cycles(30);
      chk_word(wr_cnt, base + 8'h08, "fifo drained");
      chk_word(wr_last, 32'hF000_0007, "last drained word");
      // reset in mid-run drops a held read and the application's pending request
      dt = 1'b0;
      dly = 8'h03;
      acc(`PCITIO_CMD_IO_RD, 32'h0000_7000, 0, 1'b0);
      rst = 1'b1;
      cycles(2);
      rst = 1'b0;
      chk_bit(rdy & ~resp_v & ~rd_req, 1'b1, "quiet after mid-run reset");
      acc(`PCITIO_CMD_IO_RD, 32'h0000_7000, 0, 1'b0);
      ans(1, 1, 0);
      cycles(12);
      acc(`PCITIO_CMD_IO_RD, 32'h0000_7000, 0, 1'b0);
      ans(1, 0, 1);
      chk_word(r_data, 32'h5A5A_2A5A, "read data after reset");
      // master commands, single and burst
      for (int i = 0; i < 4; i++) begin
         mwr = i[0];
         mburst = i[1];
         mreq = 1'b1;
         cycles(1);
         mreq = 1'b0;
         chk_bit(mst_c === (i[0] ? `PCITIO_CMD_IO_WR : `PCITIO_CMD_IO_RD), 1'b1, "master command");
         chk_bit(mst_b, i[1], "master burst");
      end
      tally_and_finish();
   end
endmodule : pcitio_target_tb
